// *** port_c_mux_pkg.sv ***
// Constants shared by the port C alternate-function override logic.
package port_c_mux_pkg;
  localparam int PORT_WIDTH = 8;
  localparam int BIT_EXT_IRQ = 0;
  localparam int BIT_SS_ALT = 1;
  localparam int BIT_T0 = 2;
  localparam int BIT_T1 = 3;
  localparam int BIT_DAC = 7;
  localparam int ADC_LO_BIT = 4;
  localparam int ADC_HI_BIT = 6;
  localparam int PCI_LO_BIT = 0;
  localparam int PCI_COUNT = 4;
  localparam logic [PORT_WIDTH-1:0] PORT_ZERO = 8'h00;
endpackage

// *** pin_override_if.sv ***
// Override-enable and override-value bundle for one port.
`timescale 1ns/1ps
interface pin_override_if;
  import port_c_mux_pkg::*;
  logic [PORT_WIDTH-1:0] pullup_override_en;
  logic [PORT_WIDTH-1:0] pullup_override_val;
  logic [PORT_WIDTH-1:0] direction_override_en;
  logic [PORT_WIDTH-1:0] direction_override_val;
  logic [PORT_WIDTH-1:0] out_value_override_en;
  logic [PORT_WIDTH-1:0] out_value_override_val;
  logic [PORT_WIDTH-1:0] dig_in_en_override_en;
  logic [PORT_WIDTH-1:0] dig_in_en_override_val;
  modport src (output pullup_override_en, pullup_override_val, direction_override_en,
    direction_override_val, out_value_override_en, out_value_override_val,
    dig_in_en_override_en, dig_in_en_override_val);
  modport sel (input pullup_override_en, pullup_override_val, direction_override_en,
    direction_override_val, out_value_override_en, out_value_override_val,
    dig_in_en_override_en, dig_in_en_override_val);
endinterface

// *** pin_override_sel.sv ***
// Per-pin selection between register settings and peripheral overrides.
`timescale 1ns/1ps
module pin_override_sel
  import port_c_mux_pkg::*;
(
  pin_override_if.sel ovr,
  input wire logic [PORT_WIDTH-1:0] reg_pullup,
  input wire logic [PORT_WIDTH-1:0] reg_direction,
  input wire logic [PORT_WIDTH-1:0] reg_out_value,
  input wire logic [PORT_WIDTH-1:0] reg_dig_in_en,
  output logic [PORT_WIDTH-1:0] pin_pullup,
  output logic [PORT_WIDTH-1:0] direction,
  output logic [PORT_WIDTH-1:0] out_value,
  output logic [PORT_WIDTH-1:0] dig_in_en
);
  for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_pin
    assign pin_pullup[i] = ovr.pullup_override_en[i] ?
      ovr.pullup_override_val[i] : reg_pullup[i];
    assign direction[i] = ovr.direction_override_en[i] ?
      ovr.direction_override_val[i] : reg_direction[i];
    assign out_value[i] = ovr.out_value_override_en[i] ?
      ovr.out_value_override_val[i] : reg_out_value[i];
    assign dig_in_en[i] = ovr.dig_in_en_override_en[i] ?
      ovr.dig_in_en_override_val[i] : reg_dig_in_en[i];
  end
endmodule

// *** port_c_alternate_function_override.sv ***
// Port C alternate-function override logic with the port D bit 0 slave-select control.
// Functional notes
// - Port C bit 3 clocks timer 1.
// - Port C bit 2 clocks timer 0.
// - Port C bit 3 is timer 1 capture.
// - Drive timer 1 compare-B onto bit 1.
// - SPI slave on the alternate pin set forces slave-select pin input.
// - Slave SPI active while select held low.
// - SPI master leaves select direction to register.
// - Forced input keeps pull-up via output bit.
// - Port C bit 0 feeds external interrupt 3.
// - Bits 0..3 raise pin-change lines 8..11.
// - DAC and ADC bits disable digital inputs.
// - Power stage 1A drives bit 0 output.
// - Compare-B overrides bit 1 value only.
`timescale 1ns/1ps
module port_c_alternate_function_override
  import port_c_mux_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,

  // Port C pins and register settings.
  input wire logic [PORT_WIDTH-1:0] port_c_pins_in,
  input wire logic [PORT_WIDTH-1:0] port_c_pullup_reg,
  input wire logic [PORT_WIDTH-1:0] port_c_direction_reg,
  input wire logic [PORT_WIDTH-1:0] port_c_out_reg,
  input wire logic [PORT_WIDTH-1:0] port_c_dig_in_en_reg,

  // Port D bit 0 register settings.
  input wire logic port_d_bit0_direction,
  input wire logic port_d_bit0_out_reg,
  input wire logic port_d_bit0_pullup_reg,

  // SPI mode and pin set controls.
  input wire logic spi_enable,
  input wire logic spi_master,
  input wire logic spi_alt_pins_sel,

  // Peripheral override requests.
  input wire logic timer1_compare_b_out,
  input wire logic timer1_compare_b_out_en,
  input wire logic power_stage_out_1a_en,
  input wire logic power_stage_out_1a_val,
  input wire logic external_irq_3_en,
  input wire logic dac_output_enable,
  input wire logic [ADC_HI_BIT:ADC_LO_BIT] analog_dig_in_off,

  // Effective port C pin settings.
  output logic [PORT_WIDTH-1:0] port_c_pullup,
  output logic [PORT_WIDTH-1:0] port_c_direction,
  output logic [PORT_WIDTH-1:0] port_c_out_value,
  output logic [PORT_WIDTH-1:0] port_c_dig_in_en,

  // Port D bit 0 pin controls.
  output logic port_d_bit0_pin_direction,
  output logic port_d_bit0_pin_pullup,

  // Pin levels handed to the peripherals.
  output logic timer1_ext_count_in,
  output logic timer0_ext_count_in,
  output logic timer1_alt_capture_in,
  output logic power_stage_input_1,
  output logic spi_alt_slave_select_n,
  output logic spi_slave_active,
  output logic external_irq_3,
  output logic [PCI_COUNT-1:0] pin_change_lines_8_to_11
);
  pin_override_if ovr();

  // Pin synchroniser and registered copies.
  logic [PORT_WIDTH-1:0] pin_meta_q;
  logic [PORT_WIDTH-1:0] pin_sync_q;
  logic [PORT_WIDTH-1:0] pin_gated_d;
  logic [PORT_WIDTH-1:0] pin_c_q;

  // Pin-change detection state.
  logic [PORT_WIDTH-1:0] pin_prev_q;
  logic [PORT_WIDTH-1:0] pin_seen_q;
  logic [PCI_COUNT-1:0] pin_change_d;
  logic [PCI_COUNT-1:0] pin_change_q;

  // Alternate slave-select decode.
  logic spi_slave_mode;
  logic ss_alt_level;

  // True while the SPI runs as a slave on the alternate pin set.
  function automatic logic slave_on_alt(input logic en, input logic mst, input logic alt);
    return en & ~mst & alt;
  endfunction

  // Pins are asynchronous to the core clock, so two stages come first.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_meta_q <= PORT_ZERO;
    end else begin
      pin_meta_q <= port_c_pins_in;
    end
  end

  // The second stage is the only reader of the first.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_sync_q <= PORT_ZERO;
    end else begin
      pin_sync_q <= pin_meta_q;
    end
  end

  // A pin whose digital input is switched off reads as 0 at the timers, PSC, SPI and interrupt 3, but not at change detection.
  for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_pin_gate
    assign pin_gated_d[i] = pin_sync_q[i] & port_c_dig_in_en[i];
  end

  // Registered levels feed the timers, PSC, SPI and interrupt 3.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_c_q <= PORT_ZERO;
    end else begin
      pin_c_q <= pin_gated_d;
    end
  end

  // Change detection masks only the first cycle after reset, while both compared stages still hold 0; a pin already high then counts as a change.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_prev_q <= PORT_ZERO;
      pin_seen_q <= PORT_ZERO;
    end else begin
      pin_prev_q <= pin_sync_q;
      pin_seen_q <= ~PORT_ZERO;
    end
  end

  // Each of bits 0 to 3 has its own change line, in ascending order.
  for (genvar i = 0; i < PCI_COUNT; i++) begin : g_pin_change
    assign pin_change_d[i] = (pin_sync_q[PCI_LO_BIT + i] ^ pin_prev_q[PCI_LO_BIT + i])
      & pin_seen_q[PCI_LO_BIT + i];
  end

  // The change pulse stands for one cycle.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_change_q <= '0;
    end else begin
      pin_change_q <= pin_change_d;
    end
  end

  // Timer, PSC, SPI and interrupt 3 inputs take the registered, gated pin levels; change lines come from ungated levels.
  assign pin_change_lines_8_to_11 = pin_change_q;
  assign timer1_ext_count_in = pin_c_q[BIT_T1];
  assign timer0_ext_count_in = pin_c_q[BIT_T0];
  assign timer1_alt_capture_in = pin_c_q[BIT_T1];
  assign external_irq_3 = pin_c_q[BIT_EXT_IRQ];
  assign ss_alt_level = pin_c_q[BIT_SS_ALT];
  assign power_stage_input_1 = ss_alt_level;

  // Slave select idles high while alternate pins are not selected.
  assign spi_alt_slave_select_n = spi_alt_pins_sel ? ss_alt_level : 1'b1;
  assign spi_slave_mode = slave_on_alt(spi_enable, spi_master, spi_alt_pins_sel);
  assign spi_slave_active = spi_slave_mode & ~spi_alt_slave_select_n;

  // Port D bit 0 direction: slave on the alternate pin set forces input, master leaves register in charge.
  assign port_d_bit0_pin_direction = spi_slave_mode ?
    1'b0 : port_d_bit0_direction;
  // Forced input keeps pull-up under the output register bit.
  assign port_d_bit0_pin_pullup = spi_slave_mode ?
    port_d_bit0_out_reg : port_d_bit0_pullup_reg;

  // Override bundle; pins not named here keep their register settings.
  always_comb begin
    ovr.pullup_override_en = PORT_ZERO;
    ovr.pullup_override_val = PORT_ZERO;
  end

  // DAC forces bit 7 to input; power stage 1A forces bit 0 to output.
  always_comb begin
    ovr.direction_override_en = PORT_ZERO;
    ovr.direction_override_val = PORT_ZERO;
    ovr.direction_override_en[BIT_DAC] = dac_output_enable;
    ovr.direction_override_en[BIT_EXT_IRQ] = power_stage_out_1a_en;
    ovr.direction_override_val[BIT_EXT_IRQ] = 1'b1;
  end

  // Compare-B drives bit 1 and power stage 1A drives bit 0.
  always_comb begin
    ovr.out_value_override_en = PORT_ZERO;
    ovr.out_value_override_val = PORT_ZERO;
    ovr.out_value_override_en[BIT_SS_ALT] = timer1_compare_b_out_en;
    ovr.out_value_override_val[BIT_SS_ALT] = timer1_compare_b_out;
    ovr.out_value_override_en[BIT_EXT_IRQ] = power_stage_out_1a_en;
    ovr.out_value_override_val[BIT_EXT_IRQ] = power_stage_out_1a_val;
  end

  // Analog functions switch digital inputs off; interrupt 3 keeps bit 0 on.
  always_comb begin
    ovr.dig_in_en_override_en = PORT_ZERO;
    ovr.dig_in_en_override_val = PORT_ZERO;
    ovr.dig_in_en_override_en[BIT_DAC] = dac_output_enable;
    ovr.dig_in_en_override_en[ADC_HI_BIT:ADC_LO_BIT] = analog_dig_in_off;
    ovr.dig_in_en_override_en[BIT_EXT_IRQ] = external_irq_3_en;
    ovr.dig_in_en_override_val[BIT_EXT_IRQ] = external_irq_3_en;
  end

  pin_override_sel u_sel (
    .ovr(ovr.sel),
    .reg_pullup(port_c_pullup_reg),
    .reg_direction(port_c_direction_reg),
    .reg_out_value(port_c_out_reg),
    .reg_dig_in_en(port_c_dig_in_en_reg),
    .pin_pullup(port_c_pullup),
    .direction(port_c_direction),
    .out_value(port_c_out_value),
    .dig_in_en(port_c_dig_in_en)
  );
endmodule

// *** port_c_asserts.sv ***
// Assertion checker for the port C override block.
`timescale 1ns/1ps
module port_c_asserts (
  input wire logic core_clk, reset, spi_enable, spi_master, spi_alt_pins_sel,
  input wire logic port_d_bit0_direction, port_d_bit0_out_reg, port_d_bit0_pin_direction,
  input wire logic port_d_bit0_pin_pullup, timer1_compare_b_out, timer1_compare_b_out_en,
  input wire logic power_stage_out_1a_en, power_stage_out_1a_val, dac_output_enable,
  input wire logic external_irq_3_en, external_irq_3,
  input wire logic [6:4] analog_dig_in_off,
  input wire logic [3:0] pin_change_lines_8_to_11,
  input wire logic [7:0] port_c_pins_in, port_c_pullup_reg, port_c_pullup,
  input wire logic [7:0] port_c_direction, port_c_out_value, port_c_dig_in_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire slave = spi_enable && !spi_master && spi_alt_pins_sel;
  chk_dac_input: assert property (
    dac_output_enable |-> !port_c_direction[7] && !port_c_dig_in_en[7]) else $error("dac");
  chk_adc_input_off: assert property (
    (port_c_dig_in_en[6:4] & analog_dig_in_off) == 3'h0) else $error("adc");
  chk_psc_drive: assert property (power_stage_out_1a_en |-> port_c_direction[0] &&
    port_c_out_value[0] == power_stage_out_1a_val) else $error("psc");
  chk_irq_input_on: assert property (external_irq_3_en |-> port_c_dig_in_en[0])
    else $error("irq input");
  chk_cmpb_value: assert property (timer1_compare_b_out_en |->
    port_c_out_value[1] == timer1_compare_b_out) else $error("compare b");
  chk_pullup_free: assert property (port_c_pullup == port_c_pullup_reg)
    else $error("pullup");
  chk_slave_input: assert property (slave |-> !port_d_bit0_pin_direction &&
    port_d_bit0_pin_pullup == port_d_bit0_out_reg) else $error("slave pin");
  chk_master_dir: assert property (spi_enable && spi_master |->
    port_d_bit0_pin_direction == port_d_bit0_direction) else $error("master dir");
  chk_irq_level: assert property ($past(port_c_dig_in_en[0]) && !$past(reset, 3) |->
    external_irq_3 == $past(port_c_pins_in[0], 3)) else $error("irq level");
  chk_pin_change: assert property ($changed(port_c_pins_in[0]) |->
    ##[2:4] pin_change_lines_8_to_11[0]) else $error("pin change");
  cover property (slave);
  cover property (|pin_change_lines_8_to_11);
  cover property (power_stage_out_1a_en && dac_output_enable);
endmodule

// *** periph_model.sv ***
// Peripheral stand-in making compare-B and power stage 1A waveforms.
`timescale 1ns/1ps
module periph_model (
  input wire logic core_clk,
  input wire logic reset,
  output logic timer1_compare_b_out,
  output logic power_stage_out_1a_val
);
  logic [2:0] cnt_q;
  always_ff @(negedge core_clk) cnt_q <= reset ? 3'h0 : cnt_q + 3'h1;
  assign timer1_compare_b_out = cnt_q < 3'h3;
  assign power_stage_out_1a_val = cnt_q[0];
endmodule

// *** tb_top.sv ***
// Self-checking bench for the port C override block.
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 0, reset = 1, spi_enable = 0, spi_master = 0, spi_alt_pins_sel = 1;
  logic port_d_bit0_direction = 1, port_d_bit0_out_reg = 1, port_d_bit0_pullup_reg = 0;
  logic timer1_compare_b_out_en = 0, power_stage_out_1a_en = 0, external_irq_3_en = 0;
  logic dac_output_enable = 0, timer1_compare_b_out, power_stage_out_1a_val, external_irq_3;
  logic timer1_ext_count_in, timer0_ext_count_in, timer1_alt_capture_in, power_stage_input_1;
  logic spi_alt_slave_select_n, spi_slave_active, port_d_bit0_pin_direction;
  logic port_d_bit0_pin_pullup;
  logic [6:4] analog_dig_in_off = 3'h0;
  logic [3:0] pin_change_lines_8_to_11;
  logic [7:0] port_c_pins_in = 8'h00, port_c_pullup_reg = 8'hA5, port_c_direction_reg = 8'h3E;
  logic [7:0] port_c_out_reg = 8'h96, port_c_dig_in_en_reg = 8'hFF;
  logic [7:0] port_c_pullup, port_c_direction, port_c_out_value, port_c_dig_in_en;
  int n_mismatch = 0, check_count = 0, pc_n[4] = '{0, 0, 0, 0};
  port_c_alternate_function_override u_port_c_alternate_function_override (.*);
  periph_model u_periph_model (.*);
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) for (int i = 0; i < 4; i++) pc_n[i] += pin_change_lines_8_to_11[i];
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Drives the pins, waits out the synchroniser, then checks the peripheral inputs.
  task automatic put(input logic [7:0] v, input logic [7:0] die);
    logic [7:0] o, e;
    int c[4];
    c = pc_n;
    o = port_c_pins_in;
    @(negedge core_clk);
    port_c_pins_in = v;
    port_c_dig_in_en_reg = die;
    repeat (5) @(negedge core_clk);
    e = v & (die & ~{dac_output_enable, analog_dig_in_off, 4'h0} | {7'h0, external_irq_3_en});
    chk("pin in", {timer1_ext_count_in, timer0_ext_count_in, timer1_alt_capture_in,
      power_stage_input_1, external_irq_3}, {e[3], e[2], e[3], e[1], e[0]});
    for (int i = 0; i < 4; i++) chk("pin change", pc_n[i] - c[i], {7'h0, o[i] ^ v[i]});
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    reset = 0;
    put(8'h00, 8'hFF);
    put(8'h0F, 8'hFF);
    put(8'h05, 8'hFF);
    put(8'h0A, 8'hF7);
    put(8'hF0, 8'hFF);
    $display("pin input test done");
    {dac_output_enable, power_stage_out_1a_en, external_irq_3_en, timer1_compare_b_out_en} = 4'hF;
    analog_dig_in_off = 3'h5;
    put(8'h01, 8'h7E);
    #1;
    chk("dir", port_c_direction, 8'h3F);
    chk("die", port_c_dig_in_en, 8'h2F);
    chk("out", port_c_out_value, {6'h25, timer1_compare_b_out, power_stage_out_1a_val});
    chk("pullup", port_c_pullup, port_c_pullup_reg);
    {dac_output_enable, power_stage_out_1a_en, external_irq_3_en, timer1_compare_b_out_en} = 4'h0;
    #1;
    chk("dir", port_c_direction, port_c_direction_reg);
    chk("out", port_c_out_value, port_c_out_reg);
    $display("override test done");
    spi_enable = 1;
    put(8'h00, 8'hFF);
    chk("select", {port_d_bit0_pin_direction, port_d_bit0_pin_pullup,
      spi_alt_slave_select_n, spi_slave_active}, 8'h05);
    spi_alt_pins_sel = 0;
    #1;
    chk("unselected", {spi_alt_slave_select_n, spi_slave_active,
      port_d_bit0_pin_direction}, 8'h05);
    spi_alt_pins_sel = 1;
    put(8'h02, 8'hFF);
    chk("select", {spi_alt_slave_select_n, spi_slave_active}, 8'h02);
    spi_master = 1;
    #1;
    chk("d0 dir", port_d_bit0_pin_direction, port_d_bit0_direction);
    $display("select test done");
    end_sim();
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    n_mismatch++;
    end_sim();
  end
endmodule
bind port_c_alternate_function_override port_c_asserts u_port_c_asserts (.*);
